// ===== hw/lcdd_pkg.sv
/*
 Package for the LCD instruction decoder: command codes, field positions,
 reset values, address limits and the packed setting and display mode types.
 Assumes a byte-wide receive strobe from a serial slave on the same clock.
*/
// What this block does
// - Flag low decodes command, high writes RAM
// - Function set 001 accepted in both sets
// - Basic display control loads picture and shading bits
// - Basic pump stage select, reset two times
// - Basic row bank load, bank 8 keeps one bit, MSB unless bit order set
// - Basic column load from low seven bits
// - Basic range select loads high range bit
// - Extended temperature slope two bits, reset zero
// - Extended bit order and pad flips, reset zero
// - Extended bias ratio three bits
// - Extended contrast level seven bits, reset zero
// - Commands other than function set execute only in their own set
// - Reset sets sleep and clears all settings
// - Reset leaves RAM contents untouched
// - Sleep grounds outputs, stops generators, RAM writable
// - Column mirror remaps later RAM writes
// - Row flip stored in settings and status only
// - Picture and shading pair select display mode
// - Pad flips reverse their row groups
// - Pump off when contrast and range zero
// - Pointer advances after each data byte
// - Data byte committed in acknowledge cycle
// - Last control byte fixes data or command
// - Status returned on read when flag low
package lcdd_pkg;
   // -------------------------------------------------------------------
   // Address limits
   // -------------------------------------------------------------------
   localparam logic [6:0] LCDD_COL_MAX  = 7'h65;
   localparam logic [3:0] LCDD_BANK_MAX = 4'h8;
   localparam int         LCDD_COLS     = 102;
   localparam int         LCDD_BANKS    = 9;
   localparam int         LCDD_ROWS     = 65;
   // -------------------------------------------------------------------
   // Command opcode masks
   // -------------------------------------------------------------------
   localparam logic [2:0] LCDD_OP_FSET  = 3'h1;
   localparam logic [5:0] LCDD_OP_RANGE = 6'h01;
   localparam logic [5:0] LCDD_OP_TEMP  = 6'h01;
   localparam logic [4:0] LCDD_OP_DCTL  = 5'h01;
   localparam logic [4:0] LCDD_OP_CFG   = 5'h01;
   localparam logic [5:0] LCDD_OP_PUMP  = 6'h04;
   localparam logic [4:0] LCDD_OP_BIAS  = 5'h02;
   localparam logic [3:0] LCDD_OP_BANK  = 4'h4;
   // -------------------------------------------------------------------
   // Row group bounds for pad flips
   // -------------------------------------------------------------------
   localparam int LCDD_LO_A0 = 0;
   localparam int LCDD_LO_A1 = 18;
   localparam int LCDD_UP_A0 = 19;
   localparam int LCDD_UP_A1 = 32;
   localparam int LCDD_LO_B0 = 33;
   localparam int LCDD_LO_B1 = 50;
   localparam int LCDD_UP_B0 = 51;
   localparam int LCDD_UP_B1 = 64;

   typedef struct packed {
      logic       x_mirror;
      logic       row_flip;
      logic       sleep_flag;
      logic       addressing_dir;
      logic       extended_set_sel;
      logic       picture_bit_one;
      logic       shading_bit_low;
      logic [1:0] pump_factor;
      logic       range_hi_sel;
      logic [1:0] temp_slope;
      logic       bit_order;
      logic       upper_pad_flip;
      logic       lower_pad_flip;
      logic [2:0] bias_ratio_sel;
      logic [6:0] contrast_level;
   } lcdd_cfg_t;

   localparam lcdd_cfg_t LCDD_CFG_RST = '{sleep_flag: 1'b1, default: '0};

   typedef enum logic [1:0] {
      LCDD_MODE_BLANK,
      LCDD_MODE_NORMAL,
      LCDD_MODE_ALLON,
      LCDD_MODE_INVERSE
   } lcdd_mode_t;
endpackage

// ===== hw/lcdd_decoder.sv
/*
 LCD instruction decoder with settings store, pointers and pixel store.
 Assumes the serial slave supplies byte strobes on i_clk and handles
 control bytes; i_data_or_cmd is the flag of the last control byte.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdd_decoder (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   // Received bytes
   input  wire logic                 i_byte_valid,
   input  wire logic [7:0]           i_byte,
   input  wire logic                 i_data_or_cmd,
   input  wire logic                 i_ack_phase,
   // Display scan side
   input  wire logic [3:0]           i_scan_bank,
   input  wire logic [6:0]           i_scan_col,
   // Outputs
   output logic [7:0]                o_status,
   output logic                      o_status_en,
   output logic [7:0]                o_scan_byte,
   output lcdd_pkg::lcdd_mode_t      o_mode,
   output logic                      o_pump_en,
   output logic                      o_analog_en,
   output logic                      o_outputs_grounded,
   output logic [lcdd_pkg::LCDD_ROWS-1:0] o_row_map_rev,
   output lcdd_pkg::lcdd_cfg_t       o_cfg,
   output logic [6:0]                o_col_ptr,
   output logic [3:0]                o_bank_ptr
);
   lcdd_pkg::lcdd_cfg_t cfg_reg, cfg_next;
   logic [6:0] col_reg, col_next;
   logic [3:0] bank_reg, bank_next;
   logic [7:0] pend_reg, pend_next;
   logic       pend_v_reg, pend_v_next;
   logic [7:0] scan_reg;
   // No reset on the array so contents survive reset
   logic [7:0] pixel_store [lcdd_pkg::LCDD_BANKS*lcdd_pkg::LCDD_COLS];
   logic [7:0] wr_byte;
   logic [6:0] wr_col;
   int         wr_idx;

   // -------------------------------------------------------------------
   // Command decode and pointer stepping
   // -------------------------------------------------------------------
   always_comb begin
      logic h;
      h           = cfg_reg.extended_set_sel;
      cfg_next    = cfg_reg;
      col_next    = col_reg;
      bank_next   = bank_reg;
      pend_next   = pend_reg;
      pend_v_next = pend_v_reg;
      if (i_ack_phase) begin
         pend_v_next = 1'b0;
      end
      if (i_byte_valid && i_data_or_cmd) begin
         pend_next   = i_byte;
         pend_v_next = 1'b1;
         if (cfg_reg.addressing_dir) begin
            if (bank_reg >= lcdd_pkg::LCDD_BANK_MAX) begin
               bank_next = '0;
               col_next  = (col_reg >= lcdd_pkg::LCDD_COL_MAX) ? '0 : 7'(col_reg + 7'h1);
            end else begin
               bank_next = 4'(bank_reg + 4'h1);
            end
         end else begin
            if (col_reg >= lcdd_pkg::LCDD_COL_MAX) begin
               col_next  = '0;
               bank_next = (bank_reg >= lcdd_pkg::LCDD_BANK_MAX) ? '0 : 4'(bank_reg + 4'h1);
            end else begin
               col_next = 7'(col_reg + 7'h1);
            end
         end
      end else if (i_byte_valid) begin
         if (i_byte[7:5] == lcdd_pkg::LCDD_OP_FSET) begin
            {cfg_next.x_mirror, cfg_next.row_flip, cfg_next.sleep_flag,
             cfg_next.addressing_dir, cfg_next.extended_set_sel} = i_byte[4:0];
         end else if (!h) begin
            if (i_byte[7]) begin
               col_next = i_byte[6:0];
            end else if (i_byte[7:4] == lcdd_pkg::LCDD_OP_BANK) begin
               bank_next = i_byte[3:0];
            end else if (i_byte[7:2] == lcdd_pkg::LCDD_OP_PUMP) begin
               cfg_next.pump_factor = i_byte[1:0];
            end else if (i_byte[7:3] == lcdd_pkg::LCDD_OP_DCTL && !i_byte[1]) begin
               cfg_next.picture_bit_one = i_byte[2];
               cfg_next.shading_bit_low = i_byte[0];
            end else if (i_byte[7:1] == {lcdd_pkg::LCDD_OP_RANGE, 1'b0}) begin
               cfg_next.range_hi_sel = i_byte[0];
            end
         end else begin
            if (i_byte[7]) begin
               cfg_next.contrast_level = i_byte[6:0];
            end else if (i_byte[7:3] == lcdd_pkg::LCDD_OP_BIAS) begin
               cfg_next.bias_ratio_sel = i_byte[2:0];
            end else if (i_byte[7:3] == lcdd_pkg::LCDD_OP_CFG) begin
               {cfg_next.bit_order, cfg_next.upper_pad_flip,
                cfg_next.lower_pad_flip} = i_byte[2:0];
            end else if (i_byte[7:2] == lcdd_pkg::LCDD_OP_TEMP) begin
               cfg_next.temp_slope = i_byte[1:0];
            end
            // Reserved test codes ignored; host must not send them
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_reg    <= lcdd_pkg::LCDD_CFG_RST;
         col_reg    <= '0;
         bank_reg   <= '0;
         pend_reg   <= '0;
         pend_v_reg <= 1'b0;
      end else begin
         cfg_reg    <= cfg_next;
         col_reg    <= col_next;
         bank_reg   <= bank_next;
         pend_reg   <= pend_next;
         pend_v_reg <= pend_v_next;
      end
   end

   // -------------------------------------------------------------------
   // Pixel store write, address captured with the byte
   // -------------------------------------------------------------------
   logic [6:0] wcol_reg;
   logic [3:0] wbank_reg;
   logic       wmx_reg, wdo_reg;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wcol_reg  <= '0;
         wbank_reg <= '0;
         wmx_reg   <= 1'b0;
         wdo_reg   <= 1'b0;
      end else if (i_byte_valid && i_data_or_cmd) begin
         wcol_reg  <= col_reg;
         wbank_reg <= bank_reg;
         wmx_reg   <= cfg_reg.x_mirror;
         wdo_reg   <= cfg_reg.bit_order;
      end
   end

   always_comb begin
      wr_col = wmx_reg ? 7'(lcdd_pkg::LCDD_COL_MAX - wcol_reg) : wcol_reg;
      // Stored with bit 0 as the top pixel
      wr_byte = wdo_reg ? pend_reg : {<<{pend_reg}};
      if (wbank_reg == lcdd_pkg::LCDD_BANK_MAX) begin
         wr_byte = {7'h00, wr_byte[0]};
      end
      wr_idx = int'(wbank_reg) * lcdd_pkg::LCDD_COLS + int'(wr_col);
   end

   // Writes still accepted during sleep
   always_ff @(posedge i_clk) begin
      if (pend_v_reg && i_ack_phase && wr_idx < lcdd_pkg::LCDD_BANKS*lcdd_pkg::LCDD_COLS) begin
         pixel_store[wr_idx] <= wr_byte;
      end
      if (int'(i_scan_bank) * lcdd_pkg::LCDD_COLS + int'(i_scan_col)
          < lcdd_pkg::LCDD_BANKS*lcdd_pkg::LCDD_COLS) begin
         scan_reg <= pixel_store[int'(i_scan_bank) * lcdd_pkg::LCDD_COLS + int'(i_scan_col)];
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   always_comb begin
      o_cfg      = cfg_reg;
      o_col_ptr  = col_reg;
      o_bank_ptr = bank_reg;
      o_scan_byte = scan_reg;
      o_status = {cfg_reg.sleep_flag, cfg_reg.upper_pad_flip, cfg_reg.lower_pad_flip,
                  cfg_reg.picture_bit_one, cfg_reg.shading_bit_low, cfg_reg.x_mirror,
                  cfg_reg.row_flip, cfg_reg.bit_order};
      o_status_en = !i_data_or_cmd;
      case ({cfg_reg.picture_bit_one, cfg_reg.shading_bit_low})
         2'b10:   o_mode = lcdd_pkg::LCDD_MODE_NORMAL;
         2'b01:   o_mode = lcdd_pkg::LCDD_MODE_ALLON;
         2'b11:   o_mode = lcdd_pkg::LCDD_MODE_INVERSE;
         default: o_mode = lcdd_pkg::LCDD_MODE_BLANK;
      endcase
      o_outputs_grounded = cfg_reg.sleep_flag;
      o_analog_en = !cfg_reg.sleep_flag;
      // Sleep also stops the pump
      o_pump_en = !cfg_reg.sleep_flag &&
                  ((cfg_reg.contrast_level != '0) || cfg_reg.range_hi_sel);
   end

   // Row index reversal flags from the pad flips only, row_flip not applied
   genvar r;
   generate
      for (r = 0; r < lcdd_pkg::LCDD_ROWS; r++) begin : g_row
         localparam bit UP = (r >= lcdd_pkg::LCDD_UP_A0 && r <= lcdd_pkg::LCDD_UP_A1) ||
                             (r >= lcdd_pkg::LCDD_UP_B0 && r <= lcdd_pkg::LCDD_UP_B1);
         assign o_row_map_rev[r] = UP ? cfg_reg.upper_pad_flip : cfg_reg.lower_pad_flip;
      end
   endgenerate
endmodule // lcdd_decoder
`default_nettype wire

// ===== bench/lcdd_props.sv
/* Checker for the LCD instruction decoder, watching top ports only.
   Assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module lcdd_props (
   input wire logic                 i_clk,
   input wire logic                 i_resetn,
   input wire logic                 i_byte_valid,
   input wire logic [7:0]           i_byte,
   input wire logic                 i_data_or_cmd,
   input wire logic [7:0]           o_status,
   input wire logic                 o_status_en,
   input wire lcdd_pkg::lcdd_mode_t o_mode,
   input wire logic                 o_pump_en,
   input wire logic                 o_analog_en,
   input wire logic                 o_outputs_grounded,
   input wire lcdd_pkg::lcdd_cfg_t  o_cfg,
   input wire logic [6:0]           o_col_ptr,
   input wire logic [3:0]           o_bank_ptr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire logic cmd = i_byte_valid && !i_data_or_cmd;
   sequence s_col_cmd;
      cmd && !o_cfg.extended_set_sel && i_byte[7] && i_byte[6:0] <= 7'h65;
   endsequence
   sequence s_data_h;
      i_byte_valid && i_data_or_cmd && !o_cfg.addressing_dir && o_col_ptr < 7'h65;
   endsequence
   AST_STATUS: assert property (o_status == {o_cfg.sleep_flag, o_cfg.upper_pad_flip,
      o_cfg.lower_pad_flip, o_cfg.picture_bit_one, o_cfg.shading_bit_low, o_cfg.x_mirror, o_cfg.row_flip,
      o_cfg.bit_order}) else $error("status byte wrong");
   AST_SLEEP: assert property (o_outputs_grounded == o_cfg.sleep_flag && o_analog_en != o_cfg.sleep_flag)
      else $error("sleep outputs wrong");
   AST_PUMP: assert property (o_pump_en == (!o_cfg.sleep_flag && (o_cfg.contrast_level != 7'h00
      || o_cfg.range_hi_sel))) else $error("pump enable wrong");
   AST_MODE: assert property (o_mode == {o_cfg.shading_bit_low, o_cfg.picture_bit_one})
      else $error("display mode wrong");
   AST_STEN: assert property (o_status_en == !i_data_or_cmd) else $error("status enable wrong");
   AST_COL: assert property (s_col_cmd |=> {1'b1, o_col_ptr} == $past(i_byte)) else $error("column load");
   AST_ADV: assert property (s_data_h |=> o_col_ptr == $past(o_col_ptr) + 7'h01) else $error("no advance");
   AST_DATA: assert property (i_byte_valid && i_data_or_cmd |=> $stable(o_cfg)) else $error("data hit cfg");
   AST_FSET: assert property (cmd && i_byte[7:5] == 3'h1 |=> {3'h1, o_cfg.x_mirror, o_cfg.row_flip,
      o_cfg.sleep_flag, o_cfg.addressing_dir, o_cfg.extended_set_sel} == $past(i_byte)) else $error("fset");
   AST_SET: assert property (cmd && o_cfg.extended_set_sel && i_byte[7:3] == 5'h01 |=>
      $stable({o_cfg.picture_bit_one, o_cfg.shading_bit_low})) else $error("wrong set executed");
   AST_RST: assert property ($rose(i_resetn) |-> o_cfg == lcdd_pkg::LCDD_CFG_RST && o_col_ptr == 7'h00
      && o_bank_ptr == 4'h0) else $error("reset state wrong");
endmodule // lcdd_props
bind lcdd_decoder lcdd_props u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_byte_valid(i_byte_valid),
   .i_byte(i_byte), .i_data_or_cmd(i_data_or_cmd), .o_status(o_status), .o_status_en(o_status_en),
   .o_mode(o_mode), .o_pump_en(o_pump_en), .o_analog_en(o_analog_en), .o_cfg(o_cfg),
   .o_outputs_grounded(o_outputs_grounded), .o_col_ptr(o_col_ptr), .o_bank_ptr(o_bank_ptr));
`default_nettype wire

// ===== bench/lcdd_host_model.sv
/* Host model: hands bytes to the decoder one per link period.
   Assumes the serial slave framing is already done. */
`timescale 1ns/1ps
`default_nettype none
module lcdd_host_model (
   input  wire logic  i_clk,
   input  wire logic  i_link_clk,
   output logic       o_byte_valid,
   output logic [7:0] o_byte,
   output logic       o_data_or_cmd,
   output logic       o_ack_phase
);
   initial begin
      o_byte_valid = 1'b0;
      o_byte = 8'h00;
      o_data_or_cmd = 1'b0;
      o_ack_phase = 1'b0;
   end
   // Callers keep to non-reserved codes
   task automatic send(input logic d, input logic [7:0] b);
      @(posedge i_link_clk);
      @(posedge i_clk);
      o_byte_valid <= 1'b1;
      o_byte <= b;
      o_data_or_cmd <= d;
      @(posedge i_clk);
      o_byte_valid <= 1'b0;
      o_byte <= ~b; // Released lines never keep the old byte
      @(posedge i_clk);
      o_ack_phase <= 1'b1;
      @(posedge i_clk);
      o_ack_phase <= 1'b0;
   endtask
endmodule // lcdd_host_model
`default_nettype wire

// ===== bench/lcd_instruction_decoder_test.sv
/* Testbench: command and data stream with a reference model.
   Assumes host model and checker files compiled before. */
`timescale 1ns/1ps
`default_nettype none
module lcd_instruction_decoder_test;
   logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0;
   logic bv, dc, ack;
   logic [7:0] b, sbyte;
   lcdd_pkg::lcdd_cfg_t cfg, e;
   logic [6:0] col, ec;
   logic [3:0] bank, eb;
   logic [lcdd_pkg::LCDD_ROWS-1:0] rmap;
   int errors = 0, checks_done = 0, cyc = 0;
   logic [8:0] seq [31] = '{9'h021, 9'h006, 9'h00D, 9'h012, 9'h0FF, 9'h00B, 9'h013, 9'h080, 9'h020, 9'h00D,
      9'h009, 9'h00C, 9'h008, 9'h011, 9'h012, 9'h013, 9'h010, 9'h005, 9'h004, 9'h043, 9'h0E5, 9'h1AA,
      9'h022, 9'h048, 9'h085, 9'h155, 9'h020, 9'h040, 9'h080, 9'h1C0, 9'h024};
   initial forever #50 clk = ~clk;
   initial begin
      #37;
      forever #400 lclk = ~lclk;
   end
   lcdd_host_model host (.i_clk(clk), .i_link_clk(lclk), .o_byte_valid(bv), .o_byte(b),
      .o_data_or_cmd(dc), .o_ack_phase(ack));
   lcdd_decoder dut (.i_clk(clk), .i_resetn(rstn), .i_byte_valid(bv), .i_byte(b), .i_data_or_cmd(dc),
      .i_ack_phase(ack), .i_scan_bank(4'h0), .i_scan_col(7'h00), .o_status(), .o_status_en(),
      .o_scan_byte(sbyte), .o_mode(), .o_pump_en(), .o_analog_en(), .o_outputs_grounded(),
      .o_row_map_rev(rmap), .o_cfg(cfg), .o_col_ptr(col), .o_bank_ptr(bank));
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      checks_done++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic chk_all();
      chk(32'(cfg), 32'(e), "settings");
      chk(32'(col), 32'(ec), "column");
      chk(32'(bank), 32'(eb), "bank");
      chk(32'({rmap[lcdd_pkg::LCDD_UP_A0], rmap[lcdd_pkg::LCDD_LO_A0]}),
          32'({e.upper_pad_flip, e.lower_pad_flip}), "row groups");
   endtask
   // Reference decode; pointer wrap mirrors the addressing order
   task automatic model(input logic d, input logic [7:0] c);
      if (d) begin
         if (e.addressing_dir) begin
            ec = (eb == 4'h8) ? ((ec == 7'h65) ? 7'h00 : ec + 7'h01) : ec;
            eb = (eb == 4'h8) ? 4'h0 : eb + 4'h1;
         end else begin
            eb = (ec == 7'h65) ? ((eb == 4'h8) ? 4'h0 : eb + 4'h1) : eb;
            ec = (ec == 7'h65) ? 7'h00 : ec + 7'h01;
         end
      end else if (c[7:5] == 3'h1) begin
         {e.x_mirror, e.row_flip, e.sleep_flag, e.addressing_dir, e.extended_set_sel} = c[4:0];
      end else if (!e.extended_set_sel) begin
         if (c[7]) ec = c[6:0];
         else if (c[7:4] == 4'h4) eb = c[3:0];
         else if (c[7:3] == 5'h01) {e.picture_bit_one, e.shading_bit_low} = {c[2], c[0]};
         else if (c[7:2] == 6'h04) e.pump_factor = c[1:0];
         else if (c[7:1] == 7'h02) e.range_hi_sel = c[0];
      end else begin
         if (c[7]) e.contrast_level = c[6:0];
         else if (c[7:2] == 6'h01) e.temp_slope = c[1:0];
         else if (c[7:3] == 5'h01) {e.bit_order, e.upper_pad_flip, e.lower_pad_flip} = c[2:0];
         else if (c[7:3] == 5'h02) e.bias_ratio_sel = c[2:0];
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Run is about 250 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      e = lcdd_pkg::LCDD_CFG_RST;
      ec = 7'h00;
      eb = 4'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk_all();
      foreach (seq[i]) begin
         model(seq[i][8], seq[i][7:0]);
         host.send(seq[i][8], seq[i][7:0]);
         chk_all();
      end
      repeat (2) @(posedge clk);
      chk(32'(sbyte), 32'h03, "stored byte");
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      e = lcdd_pkg::LCDD_CFG_RST;
      ec = 7'h00;
      eb = 4'h0;
      repeat (2) @(posedge clk);
      chk_all();
      chk(32'(sbyte), 32'h03, "kept byte");
      end_of_test();
   end
endmodule // lcd_instruction_decoder_test
`default_nettype wire
